// ---- shared/spcc_defines.svh ----
// constants of the system power and clock control block
`ifndef SPCC_DEFINES_SVH
`define SPCC_DEFINES_SVH
`define SPCC_NUM_EINT 3
`define SPCC_NUM_PERIPH 8
`define SPCC_VEC_BASE 32'h0000_0000
`define SPCC_DIV_QUARTER 2'h0
`define SPCC_DIV_FULL 2'h1
`define SPCC_DIV_HALF 2'h2
`define SPCC_LIM_FULL 2'h0
`define SPCC_LIM_HALF 2'h1
`define SPCC_LIM_QUARTER 2'h3
`define SPCC_ST_RUN 3'h1
`define SPCC_ST_IDLE 3'h2
`define SPCC_ST_PDOWN 3'h4
`endif

// ---- shared/spcc_pkg.sv ----
// types of the system power and clock control block
`include "spcc_defines.svh"
package spcc_pkg;
  // one-hot power state
  typedef enum logic [2:0] {
    SPCC_RUN = `SPCC_ST_RUN,
    SPCC_IDLE = `SPCC_ST_IDLE,
    SPCC_PDOWN = `SPCC_ST_PDOWN
  } spcc_state_type;
  // external interrupt configuration per input
  typedef struct packed {
    logic [`SPCC_NUM_EINT-1:0] pin_sel;
    logic [`SPCC_NUM_EINT-1:0] wake_en;
  } spcc_eint_cfg_type;
  // chip-wide power status
  typedef struct packed {
    logic cpu_run;
    logic osc_en;
    logic hold_pins;
  } spcc_status_type;
endpackage

// ---- logic/spcc_top.sv ----
// system power and clock control: divider, low-power modes, gating, remap, eint
// Function
// - three external interrupt inputs via pin mux
// - each input may wake from power-down
// - vector area mapped from flash or RAM
// - idle halts processor until reset or interrupt
// - peripheral clocks keep running during idle
// - power-down stops oscillator and all clocks
// - power-down retains state and holds pins
// - leave power-down on reset or clockless interrupt
// - separate clock enable for each peripheral
// - peripheral clock full, half or quarter rate
// - divider resets to quarter rate
// - idle keeps the multiplying loop running
`timescale 1ns/1ps
`include "spcc_defines.svh"
module spcc_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [`SPCC_NUM_EINT-1:0] eint_pin_i,
  input wire spcc_pkg::spcc_eint_cfg_type eint_cfg_i,
  input wire logic irq_i,
  input wire logic idle_req_i,
  input wire logic pdown_req_i,
  input wire logic map_ram_i,
  input wire logic [1:0] div_sel_i,
  input wire logic [`SPCC_NUM_PERIPH-1:0] periph_en_i,
  input wire logic pll_en_i,
  output logic [`SPCC_NUM_EINT-1:0] eint_o,
  output logic vec_from_ram_o,
  output logic [31:0] vec_base_o,
  output logic pclk_en_o,
  output logic [1:0] div_o,
  output logic [`SPCC_NUM_PERIPH-1:0] periph_clk_en_o,
  output logic pll_run_o,
  output spcc_pkg::spcc_status_type status_o,
  output logic [2:0] state_o
);

  spcc_pkg::spcc_state_type state_q; // current power state
  spcc_pkg::spcc_state_type state_d; // next power state
  logic [1:0] div_q; // active divider ratio
  logic [1:0] cnt_q; // phase within a peripheral clock period
  logic [1:0] lim; // last phase for the active ratio
  logic [`SPCC_NUM_EINT-1:0] eint_act; // inputs routed to interrupt function
  logic eint_any; // any routed input asserted
  logic wake_any; // any routed input armed for wake
  logic boundary; // end of current peripheral clock period

  // route pins to interrupt function only when the mux selects it
  genvar gi;
  generate
    for (gi = 0; gi < `SPCC_NUM_EINT; gi++)
    begin : g_eint
      assign eint_act[gi] = eint_pin_i[gi] & eint_cfg_i.pin_sel[gi];
    end
  endgenerate

  assign eint_any = |eint_act;
  // level detection needs no running clock, so it can end power-down
  assign wake_any = |(eint_act & eint_cfg_i.wake_en);

  // period length for the active ratio; reserved code falls back to quarter
  always_comb
  begin
    case (div_q)
      `SPCC_DIV_FULL: lim = `SPCC_LIM_FULL;
      `SPCC_DIV_HALF: lim = `SPCC_LIM_HALF;
      default: lim = `SPCC_LIM_QUARTER;
    endcase
  end

  assign boundary = (cnt_q == lim);

  // power state sequencing; power-down request beats idle request
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      spcc_pkg::SPCC_RUN:
      begin
        if (pdown_req_i)
          state_d = spcc_pkg::SPCC_PDOWN;
        else if (idle_req_i)
          state_d = spcc_pkg::SPCC_IDLE;
      end
      spcc_pkg::SPCC_IDLE:
      begin
        if (irq_i || eint_any)
          state_d = spcc_pkg::SPCC_RUN;
      end
      spcc_pkg::SPCC_PDOWN:
      begin
        if (wake_any)
          state_d = spcc_pkg::SPCC_RUN;
      end
      default: state_d = spcc_pkg::SPCC_RUN;
    endcase
  end

  // state register; reset always returns to run
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_q <= spcc_pkg::SPCC_RUN;
    else
      state_q <= state_d;
  end

  // status outputs follow the next state so they line up with state_q
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      status_o <= 3'h6;
      state_o <= `SPCC_ST_RUN;
    end
    else
    begin
      status_o.cpu_run <= (state_d == spcc_pkg::SPCC_RUN);
      status_o.osc_en <= (state_d != spcc_pkg::SPCC_PDOWN);
      status_o.hold_pins <= (state_d == spcc_pkg::SPCC_PDOWN);
      state_o <= state_d;
    end
  end

  // divider phase counter; frozen in power-down so it resumes intact
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= 2'h0;
      div_q <= `SPCC_DIV_QUARTER;
    end
    else if (state_q != spcc_pkg::SPCC_PDOWN)
    begin
      if (boundary)
      begin
        cnt_q <= 2'h0;
        // loading only here avoids a clipped peripheral clock phase
        div_q <= div_sel_i;
      end
      else
        cnt_q <= cnt_q + 2'h1;
    end
  end

  // peripheral clock enable pulse; idle keeps it going, power-down stops it
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pclk_en_o <= 1'h0;
    else
      pclk_en_o <= boundary && (state_q != spcc_pkg::SPCC_PDOWN);
  end

  // per-peripheral gates and the multiplying loop enable
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      periph_clk_en_o <= '0;
      pll_run_o <= 1'h0;
    end
    else
    begin
      periph_clk_en_o <= (state_d == spcc_pkg::SPCC_PDOWN) ? '0 : periph_en_i;
      pll_run_o <= pll_en_i && (state_d != spcc_pkg::SPCC_PDOWN);
    end
  end

  // interrupt requests, divider readback and vector mapping
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      eint_o <= '0;
      div_o <= `SPCC_DIV_QUARTER;
      vec_from_ram_o <= 1'h0;
      vec_base_o <= `SPCC_VEC_BASE;
    end
    else
    begin
      eint_o <= eint_act;
      div_o <= div_q;
      vec_from_ram_o <= map_ram_i;
      vec_base_o <= `SPCC_VEC_BASE;
    end
  end

  // checks
  property p_idle_halt;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_q == spcc_pkg::SPCC_IDLE && !irq_i && !eint_any) |=> !status_o.cpu_run;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("cpu ran in idle");

  property p_idle_pclk;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_q == spcc_pkg::SPCC_IDLE && boundary) |=> pclk_en_o;
  endproperty
  a_idle_pclk: assert property (p_idle_pclk) else $error("pclk stopped in idle");

  property p_pdown_off;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_o == `SPCC_ST_PDOWN) |-> (!status_o.osc_en && periph_clk_en_o == '0 && !pll_run_o);
  endproperty
  a_pdown_off: assert property (p_pdown_off) else $error("clock alive in power-down");

  property p_pdown_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_q == spcc_pkg::SPCC_PDOWN) |=> ($stable(div_q) && $stable(cnt_q) && !pclk_en_o);
  endproperty
  a_pdown_hold: assert property (p_pdown_hold) else $error("state moved in power-down");

  property p_wake;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_q == spcc_pkg::SPCC_PDOWN && wake_any) |=> (status_o.cpu_run && status_o.osc_en);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from power-down");

  property p_gate;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_d != spcc_pkg::SPCC_PDOWN) |=> (periph_clk_en_o == $past(periph_en_i));
  endproperty
  a_gate: assert property (p_gate) else $error("peripheral gate mismatch");

  property p_half;
    @(posedge clk_i) disable iff (!rstn_i)
    // a power-down entered right after the boundary freezes the count legally
    (div_q == `SPCC_DIV_HALF && div_sel_i == `SPCC_DIV_HALF && state_q == spcc_pkg::SPCC_RUN
      && state_d != spcc_pkg::SPCC_PDOWN && boundary) |=> !boundary ##1 boundary;
  endproperty
  a_half: assert property (p_half) else $error("half rate period wrong");

  property p_div_boundary;
    @(posedge clk_i) disable iff (!rstn_i)
    !$past(boundary) |-> $stable(div_q);
  endproperty
  a_div_boundary: assert property (p_div_boundary) else $error("ratio changed mid period");

  property p_pll_idle;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_d == spcc_pkg::SPCC_IDLE && pll_en_i) |=> pll_run_o;
  endproperty
  a_pll_idle: assert property (p_pll_idle) else $error("loop stopped in idle");

endmodule // spcc_top

// ---- tb/spcc_core_model.sv ----
// processor-side model that raises an interrupt a set time after idle begins
`timescale 1ns/1ps
`include "spcc_defines.svh"
module spcc_core_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] state_i,
  input wire logic [3:0] delay_i,
  output logic irq_o
);
  logic [3:0] cnt_q; // cycles spent in idle, saturating
  // count idle cycles; leaving idle restarts the count
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= 4'h0;
    end
    else if (state_i != `SPCC_ST_IDLE)
    begin
      cnt_q <= 4'h0;
    end
    else if (cnt_q != 4'hF)
    begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // a delay of zero answers at once, a larger one stalls the wake
  assign irq_o = (state_i == `SPCC_ST_IDLE) && (cnt_q >= delay_i);
endmodule // spcc_core_model

// ---- tb/tb.sv ----
// self-checking bench of the power and clock control block
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] pin = 3'h0;
  spcc_pkg::spcc_eint_cfg_type cfg = '0;
  logic idle = 1'b0;
  logic pdn = 1'b0;
  logic map = 1'b0;
  logic pll = 1'b1;
  logic [1:0] dsel = 2'h0;
  logic [7:0] pen = 8'h00;
  logic [3:0] dly = 4'h0;
  logic irq, ram, pce, pllr;
  logic [2:0] eint, st;
  logic [31:0] vb;
  logic [1:0] divq;
  logic [7:0] pgate;
  spcc_pkg::spcc_status_type stat;
  int err_total = 0;
  int checked = 0;
  int n;
  logic [1:0] sel_t [4] = '{2'h1, 2'h2, 2'h0, 2'h3}; // every ratio code
  int per_t [4] = '{1, 2, 4, 4}; // expected pulse spacing
  always #20 clk_i = ~clk_i;
  spcc_top spcc_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .eint_pin_i(pin),
    .eint_cfg_i(cfg), .irq_i(irq), .idle_req_i(idle), .pdown_req_i(pdn),
    .map_ram_i(map), .div_sel_i(dsel), .periph_en_i(pen), .pll_en_i(pll),
    .eint_o(eint), .vec_from_ram_o(ram), .vec_base_o(vb), .pclk_en_o(pce),
    .div_o(divq), .periph_clk_en_o(pgate), .pll_run_o(pllr), .status_o(stat),
    .state_o(st));
  spcc_core_model spcc_core_model_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .state_i(st), .delay_i(dly), .irq_o(irq));
  // inputs move and outputs are read on the falling edge only
  task step(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // cycles from the present falling edge to the next divider pulse, bounded
  task gap(output int c);
    c = 0;
    do
    begin
      step(1);
      c++;
    end while (pce !== 1'b1 && c < 20);
  endtask
  // cycles from one divider pulse to the next, bounded against a stuck divider
  task period(output int c);
    c = 0;
    while (pce !== 1'b1 && c < 20)
    begin
      step(1);
      c++;
    end
    gap(c);
  endtask
  task wait_state(input logic [2:0] e);
    n = 0;
    while (st !== e && n < 20)
    begin
      step(1);
      n++;
    end
  endtask
  task end_of_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard at 5000 cycles, well beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    step(5);
    chk("state", 32'h1, st);
    chk("status", 32'h6, stat);
    chk("div", 32'h0, divq);
    chk("vbase", 32'h0, vb);
    rstn_i = 1'b1;
    period(n);
    chk("quarter", 4, n);
    for (int i = 0; i < 4; i++)
    begin
      dsel = sel_t[i];
      period(n);
      period(n);
      chk("period", per_t[i], n);
      if (i < 3) chk("div", sel_t[i], divq);
    end
    // a switch one cycle into a quarter period must not cut it short
    period(n);
    step(1);
    dsel = 2'h1;
    // the running quarter period still has three cycles to go
    gap(n);
    chk("boundary", 3, n);
    period(n);
    chk("full", 1, n);
    pen = 8'hA5;
    map = 1'b1;
    cfg.pin_sel = 3'h5;
    pin = 3'h7;
    step(1);
    chk("gates", 32'hA5, pgate);
    chk("ram", 32'h1, ram);
    chk("vbase", 32'h0, vb);
    chk("eint", 32'h5, eint);
    pin = 3'h0;
    // prompt and stalled wake from idle
    for (int d = 0; d < 7; d += 6)
    begin
      dly = d[3:0];
      idle = 1'b1;
      step(1);
      idle = 1'b0;
      chk("state", 32'h2, st);
      chk("cpu_run", 32'h0, stat.cpu_run);
      chk("gates", 32'hA5, pgate);
      chk("pll", 32'h1, pllr);
      if (d != 0) period(n);
      if (d != 0) chk("idle_pclk", 1, n);
      wait_state(3'h1);
      chk("state", 32'h1, st);
    end
    // input 2 is routed and armed, input 0 is routed but not armed
    cfg.wake_en = 3'h4;
    pdn = 1'b1;
    step(1);
    pdn = 1'b0;
    chk("state", 32'h4, st);
    chk("status", 32'h1, stat);
    chk("gates", 32'h00, pgate);
    chk("pll", 32'h0, pllr);
    n = 0;
    repeat (8)
    begin
      step(1);
      n += pce;
    end
    chk("pulses", 0, n);
    chk("div", 32'h1, divq);
    pin = 3'h1;
    step(3);
    chk("state", 32'h4, st);
    pin = 3'h4;
    wait_state(3'h1);
    chk("state", 32'h1, st);
    chk("gates", 32'hA5, pgate);
    pin = 3'h0;
    pdn = 1'b1;
    step(1);
    pdn = 1'b0;
    rstn_i = 1'b0;
    step(1);
    rstn_i = 1'b1;
    step(1);
    chk("state", 32'h1, st);
    chk("status", 32'h6, stat);
    chk("div", 32'h0, divq);
    end_of_test();
  end
endmodule // tb
